// >>> design/loce_map.svh
/*
 * Constants of the ladder output control executor: sizes, field positions,
 * instruction codes and time bases.
 * Assumes inclusion by bare name from the package and from every design file.
 */
`ifndef LOCE_MAP_SVH
`define LOCE_MAP_SVH

// ****************************************
// sizes
// ****************************************
`define LOCE_STEPS      256
`define LOCE_PC_W       8
`define LOCE_PC_LAST    8'hff
`define LOCE_DEV_N      256
`define LOCE_DEV_W      8
`define LOCE_TC_N       32
`define LOCE_TC_W       5
`define LOCE_CNT_W      16
`define LOCE_SET_W      11
`define LOCE_SRC_W      9
`define LOCE_OP_W       4
`define LOCE_LVL_N      8
`define LOCE_LVL_W      3

// ****************************************
// device address space
// ****************************************
`define LOCE_X_N        64
`define LOCE_X_W        6
`define LOCE_Y_BASE     64
`define LOCE_Y_TOP      127
`define LOCE_SRC_TC_BIT 8
`define LOCE_DEV_ZERO   8'h00

// ****************************************
// instruction codes
// ****************************************
`define LOCE_OP_IDLE    4'h0
`define LOCE_OP_END     4'h1
`define LOCE_OP_OUT     4'h2
`define LOCE_OP_SET     4'h3
`define LOCE_OP_RST     4'h4
`define LOCE_OP_RISE       4'h5
`define LOCE_OP_FALL       4'h6
`define LOCE_OP_SHIFT      4'h7
`define LOCE_OP_SHIFT_EDGE 4'h8
`define LOCE_OP_GATE_OPEN  4'h9
`define LOCE_OP_GATE_CLOSE 4'ha
`define LOCE_OP_TMR100  4'hb
`define LOCE_OP_TMR10   4'hc
`define LOCE_OP_RTMR    4'hd
`define LOCE_OP_CNT     4'he
`define LOCE_OP_RSTTC   4'hf

// ****************************************
// time bases
// ****************************************
`define LOCE_CLK_KHZ    50000
`define LOCE_TB10_MS    10
`define LOCE_TB100_MS   100

`endif

// >>> design/loce_pkg.sv
/*
 * Types of the ladder output control executor.
 * Assumes loce_map.svh is reachable on the include path.
 */
`include "loce_map.svh"

package loce_pkg;

   // ****************************************
   // program word
   // ****************************************
   typedef struct packed {
      logic [`LOCE_OP_W-1:0]  op;
      logic [`LOCE_SRC_W-1:0] src;
      logic [`LOCE_DEV_W-1:0] dst;
      logic [`LOCE_SET_W-1:0] arg;
   } loce_instr_t;

   typedef struct packed {
      logic [`LOCE_CNT_W-1:0] count;
      logic                   coil;
      logic                   contact;
   } loce_tc_t;

   typedef enum logic [1:0] {LOCE_STOP, LOCE_CHECK, LOCE_RUN, LOCE_ERROR} loce_mode_t;

   typedef struct packed {
      loce_mode_t                 mode;
      logic [`LOCE_PC_W-1:0]      pc;
      logic [`LOCE_DEV_N-1:0]     dev;
      logic [`LOCE_STEPS-1:0]     prev;
      loce_tc_t [`LOCE_TC_N-1:0]  tc;
      logic                       pend10;
      logic                       pend100;
      logic                       cur10;
      logic                       cur100;
      logic                       done;
   } loce_state_t;

   typedef struct packed {
      logic [`LOCE_LVL_N-1:0] en;
   } loce_gate_state_t;

endpackage : loce_pkg

// >>> design/loce_tick.sv
/*
 * Time base divider: one-cycle enable every CYC clocks.
 * Assumes a single clock and a synchronous active-high reset.
 */
`include "loce_map.svh"

module loce_tick #(
   parameter int CYC = 500000
) (
   input  wire logic clock_in,
   input  wire logic rst_in,
   output logic      tick_out
);
   import loce_pkg::*;

   localparam int W = $clog2(CYC);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } loce_tick_state_t;

   loce_tick_state_t s;
   loce_tick_state_t next_s;

   always_comb
   begin
      next_s = s;
      next_s.tick = 1'b0;
      if (s.cnt == W'(CYC - 1))
      begin
         next_s.cnt = '0;
         next_s.tick = 1'b1;
      end
      else
      begin
         next_s.cnt = s.cnt + W'(1);
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         s <= '0;
      else
         s <= next_s;
   end

   assign tick_out = s.tick;

endmodule : loce_tick

// >>> design/loce_mc_nest.sv
/*
 * Master control nesting: one enable per nesting level, ANDed into a gate.
 * Assumes the executor pulses open/close for one cycle per instruction.
 */
`include "loce_map.svh"

module loce_mc_nest (
   input  wire logic                   clock_in,
   input  wire logic                   rst_in,
   input  wire logic                   clear_in,
   input  wire logic                   open_in,
   input  wire logic                   close_in,
   input  wire logic [`LOCE_LVL_W-1:0] level_in,
   input  wire logic                   cond_in,
   output logic                        gate_out
);
   import loce_pkg::*;

   loce_gate_state_t s;
   loce_gate_state_t next_s;

   // one close releases its own level and every deeper one
   function automatic logic [`LOCE_LVL_N-1:0] release_from(input logic [`LOCE_LVL_N-1:0] en,
                                                             input logic [`LOCE_LVL_W-1:0] lvl);
      logic [`LOCE_LVL_N-1:0] r;
      r = en;
      for (int k = 0; k < `LOCE_LVL_N; k++)
      begin
         if (k >= int'(lvl))
            r[k] = 1'b1;
      end
      return r;
   endfunction : release_from

   always_comb
   begin
      next_s = s;
      if (clear_in)
         next_s.en = '1;
      else if (open_in)
         next_s.en[level_in] = cond_in;
      else if (close_in)
         next_s.en = release_from(s.en, level_in);
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         s <= '1;
      else
         s <= next_s;
   end

   assign gate_out = &s.en;

endmodule : loce_mc_nest

// >>> design/loce_exec.sv
/*
 * Ladder output control executor: runs a stored program one step per clock,
 * covering pulse outputs, bit shift, master control, timers, counters,
 * coil output, end of program and no operation.
 * Assumes the program is loaded while stopped and inputs are synchronous.
 */
`include "loce_map.svh"

// Functional notes
// - rising pulse drives target on for exactly one scan on off-to-on
// - falling pulse drives target on for exactly one scan on on-to-off
// - stop then run again does not refire an already executed pulse
// - shift copies the lower neighbour bit into target, then clears it
// - master control on: region instructions give their normal results
// - master control off: region is still scanned, scan does not shorten
// - disabled region: plain timers cleared, coil and contact off
// - disabled region: retentive timers, counters lose coil, keep count, contact
// - disabled region: coil output bits turn off
// - master control on drives its control bit; program uses it nowhere else
// - one nesting level may be reused with different control bits
// - close ends region and cancels control; no contact directly before it
// - eight nesting levels, lowest to highest index
// - one close at the lowest open level ends all open controls
// - end of program stops the scan and restarts at step zero
// - program without end of program raises error and does not run
// - no operation changes nothing but takes one step
module loce_exec #(
   parameter int TICK10_CYC  = `LOCE_TB10_MS * `LOCE_CLK_KHZ,
   parameter int TICK100_CYC = `LOCE_TB100_MS * `LOCE_CLK_KHZ
) (
   input  wire logic                    clock_in,
   input  wire logic                    rst_in,
   input  wire logic                    run_in,
   input  wire logic                    prog_we_in,
   input  wire logic [`LOCE_PC_W-1:0]   prog_addr_in,
   input  wire loce_pkg::loce_instr_t   prog_data_in,
   input  wire logic [`LOCE_X_N-1:0]    x_in,
   output logic [`LOCE_X_N-1:0]         y_out,
   output logic [`LOCE_PC_W-1:0]        step_out,
   output logic                         running_out,
   output logic                         error_out,
   output logic                         scan_done_out
);
   import loce_pkg::*;

   // ****************************************
   // storage and state
   // ****************************************
   loce_instr_t prog_mem [0:`LOCE_STEPS-1];
   loce_state_t s;
   loce_state_t next_s;
   loce_instr_t ins;
   logic        cmd;
   logic        gated;
   logic        gate_ok;
   logic        gate_open;
   logic        gate_close;
   logic        gate_clear;
   logic        tick10;
   logic        tick100;
   logic [`LOCE_TC_W-1:0]  idx;
   logic [`LOCE_CNT_W-1:0] setv;

   // ****************************************
   // decode helpers
   // ****************************************
   function automatic logic read_src(input loce_state_t st,
                                     input logic [`LOCE_X_N-1:0] x,
                                     input logic [`LOCE_SRC_W-1:0] a);
      logic r;
      r = 1'b0;
      if (a[`LOCE_SRC_TC_BIT])
         r = st.tc[a[`LOCE_TC_W-1:0]].contact;
      else if (a[`LOCE_DEV_W-1:0] < `LOCE_DEV_W'(`LOCE_X_N))
         r = x[a[`LOCE_X_W-1:0]];
      else
         r = st.dev[a[`LOCE_DEV_W-1:0]];
      return r;
   endfunction : read_src

   // one timer step: count while energised, at most one increment per scan
   function automatic loce_tc_t timer_on(input loce_tc_t t,
                                         input logic tick,
                                         input logic [`LOCE_CNT_W-1:0] sv);
      loce_tc_t r;
      r = t;
      r.coil = 1'b1;
      if (tick && (sv == '0 || r.count < sv) && r.count != '1)
         r.count = r.count + `LOCE_CNT_W'(1);
      r.contact = (sv != '0) && (r.count >= sv);
      return r;
   endfunction : timer_on

   // ****************************************
   // submodules
   // ****************************************
   loce_tick #(
      .CYC      (TICK10_CYC)
   ) u_tick10 (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .tick_out (tick10)
   );

   loce_tick #(
      .CYC      (TICK100_CYC)
   ) u_tick100 (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .tick_out (tick100)
   );

   loce_mc_nest u_gate (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .clear_in (gate_clear),
      .open_in  (gate_open),
      .close_in (gate_close),
      .level_in (ins.arg[`LOCE_LVL_W-1:0]),
      .cond_in  (cmd),
      .gate_out (gate_ok)
   );

   // ****************************************
   // program store
   // ****************************************
   // writes are only taken while stopped so a running scan never sees a torn program
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < `LOCE_STEPS; i++)
            prog_mem[i] <= '0;
      end
      else if (prog_we_in && s.mode == LOCE_STOP)
      begin
         prog_mem[prog_addr_in] <= prog_data_in;
      end
   end

   // ****************************************
   // executor
   // ****************************************
   assign ins      = prog_mem[s.pc];
   assign cmd      = read_src(s, x_in, ins.src);
   assign gated    = cmd & gate_ok;
   assign idx      = ins.dst[`LOCE_TC_W-1:0];
   assign setv     = `LOCE_CNT_W'(ins.arg);
   assign gate_open  = (s.mode == LOCE_RUN) && run_in && (ins.op == `LOCE_OP_GATE_OPEN);
   assign gate_close = (s.mode == LOCE_RUN) && run_in && (ins.op == `LOCE_OP_GATE_CLOSE);
   assign gate_clear = (s.mode != LOCE_RUN) || (ins.op == `LOCE_OP_END);

   always_comb
   begin
      next_s = s;
      next_s.done = 1'b0;
      // tick arriving on the end step is not lost: it is folded into the next scan
      next_s.pend10 = s.pend10 | tick10;
      next_s.pend100 = s.pend100 | tick100;
      case (s.mode)
         LOCE_STOP:
         begin
            next_s.pc = '0;
            if (run_in)
               next_s.mode = LOCE_CHECK;
         end
         LOCE_CHECK:
         begin
            if (!run_in)
            begin
               next_s.mode = LOCE_STOP;
               next_s.pc = '0;
            end
            else if (ins.op == `LOCE_OP_END)
            begin
               next_s.mode = LOCE_RUN;
               next_s.pc = '0;
            end
            else if (s.pc == `LOCE_PC_LAST)
               next_s.mode = LOCE_ERROR;
            else
               next_s.pc = s.pc + `LOCE_PC_W'(1);
         end
         LOCE_RUN:
         begin
            if (!run_in)
            begin
               // edge copies survive stop so a pulse is not refired on restart
               next_s.mode = LOCE_STOP;
               next_s.pc = '0;
            end
            else
            begin
               // every step is visited whatever the gate, so scan length is fixed
               next_s.pc = s.pc + `LOCE_PC_W'(1);
               case (ins.op)
                  `LOCE_OP_OUT:
                     next_s.dev[ins.dst] = gated;
                  `LOCE_OP_SET:
                     if (gated)
                        next_s.dev[ins.dst] = 1'b1;
                  `LOCE_OP_RST:
                     if (gated)
                        next_s.dev[ins.dst] = 1'b0;
                  `LOCE_OP_RISE:
                  begin
                     next_s.dev[ins.dst] = gated & ~s.prev[s.pc];
                     next_s.prev[s.pc] = gated;
                  end
                  `LOCE_OP_FALL:
                  begin
                     next_s.dev[ins.dst] = ~gated & s.prev[s.pc];
                     next_s.prev[s.pc] = gated;
                  end
                  `LOCE_OP_SHIFT:
                     if (gated && ins.dst != `LOCE_DEV_ZERO)
                     begin
                        next_s.dev[ins.dst] = s.dev[ins.dst - `LOCE_DEV_W'(1)];
                        next_s.dev[ins.dst - `LOCE_DEV_W'(1)] = 1'b0;
                     end
                  `LOCE_OP_SHIFT_EDGE:
                  begin
                     if (gated && !s.prev[s.pc] && ins.dst != `LOCE_DEV_ZERO)
                     begin
                        next_s.dev[ins.dst] = s.dev[ins.dst - `LOCE_DEV_W'(1)];
                        next_s.dev[ins.dst - `LOCE_DEV_W'(1)] = 1'b0;
                     end
                     next_s.prev[s.pc] = gated;
                  end
                  `LOCE_OP_GATE_OPEN:
                     next_s.dev[ins.dst] = gated;
                  `LOCE_OP_TMR100:
                     if (gated)
                        next_s.tc[idx] = timer_on(s.tc[idx], s.cur100, setv);
                     else
                        next_s.tc[idx] = '0;
                  `LOCE_OP_TMR10:
                     if (gated)
                        next_s.tc[idx] = timer_on(s.tc[idx], s.cur10, setv);
                     else
                        next_s.tc[idx] = '0;
                  `LOCE_OP_RTMR:
                     if (gated)
                        next_s.tc[idx] = timer_on(s.tc[idx], s.cur100, setv);
                     else
                        next_s.tc[idx].coil = 1'b0;
                  `LOCE_OP_CNT:
                  begin
                     // a setting of zero behaves as one
                     if (gated && !s.tc[idx].coil && !s.tc[idx].contact)
                     begin
                        next_s.tc[idx].count = s.tc[idx].count + `LOCE_CNT_W'(1);
                        next_s.tc[idx].contact = (s.tc[idx].count + `LOCE_CNT_W'(1)) >=
                                                 ((setv == '0) ? `LOCE_CNT_W'(1) : setv);
                     end
                     next_s.tc[idx].coil = gated;
                  end
                  `LOCE_OP_RSTTC:
                     if (gated)
                        next_s.tc[idx] = '0;
                  `LOCE_OP_END:
                  begin
                     next_s.pc = '0;
                     next_s.done = 1'b1;
                     next_s.cur10 = s.pend10 | tick10;
                     next_s.cur100 = s.pend100 | tick100;
                     next_s.pend10 = 1'b0;
                     next_s.pend100 = 1'b0;
                  end
                  default:
                  begin
                     // no operation and close only take their step here
                     next_s.pc = s.pc + `LOCE_PC_W'(1);
                  end
               endcase
            end
         end
         LOCE_ERROR:
         begin
            if (!run_in)
               next_s.mode = LOCE_STOP;
         end
         default:
            next_s.mode = LOCE_STOP;
      endcase
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         s <= '0;
      else
         s <= next_s;
   end

   // ****************************************
   // outputs
   // ****************************************
   assign y_out         = s.dev[`LOCE_Y_TOP:`LOCE_Y_BASE];
   assign step_out      = s.pc;
   assign running_out   = (s.mode == LOCE_RUN);
   assign error_out     = (s.mode == LOCE_ERROR);
   assign scan_done_out = s.done;

endmodule : loce_exec

// >>> sim/loce_exec_sva.sv
/*
 * Checker of the ladder output control executor, bound to its ports.
 * Assumes one clock, synchronous active-high reset, program loaded while stopped.
 */
`include "loce_map.svh"

module loce_exec_sva (
   input wire logic                  clock_in,
   input wire logic                  rst_in,
   input wire logic                  run_in,
   input wire logic [`LOCE_X_N-1:0]  y_out,
   input wire logic [`LOCE_PC_W-1:0] step_out,
   input wire logic                  running_out,
   input wire logic                  error_out,
   input wire logic                  scan_done_out
);
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);

   a_error_blocks_run: assert property (error_out |-> !running_out)
      else $error("running while in error");
   a_error_stands: assert property (error_out && run_in |=> error_out)
      else $error("error left while run requested");
   a_error_rise: assert property ($rose(error_out) |-> !$past(running_out) && $past(run_in))
      else $error("error raised outside checking");
   a_done_at_zero: assert property (scan_done_out |-> step_out == 8'h00)
      else $error("scan end not back at step zero");
   a_done_from_run: assert property (scan_done_out |-> $past(running_out))
      else $error("scan end without running");
   a_run_starts_zero: assert property ($rose(running_out) |-> step_out == 8'h00 && $past(run_in))
      else $error("run entered off step zero");
   a_step_advance: assert property (running_out && $past(running_out) && step_out != 8'h00
                                    |-> step_out == $past(step_out) + 8'h01)
      else $error("step skipped within a scan");
   a_stop_resets: assert property (running_out && !run_in |=> !running_out && step_out == 8'h00)
      else $error("stop request not honoured");
   // outputs only move as a result of an executed step
   a_y_only_run: assert property ($changed(y_out) |-> $past(running_out))
      else $error("outputs changed while not running");

   c_scan_done: cover property (scan_done_out);
   c_error: cover property ($rose(error_out));
   c_run: cover property ($rose(running_out));
endmodule : loce_exec_sva

bind loce_exec loce_exec_sva chk_u (
   .clock_in      (clock_in),
   .rst_in        (rst_in),
   .run_in        (run_in),
   .y_out         (y_out),
   .step_out      (step_out),
   .running_out   (running_out),
   .error_out     (error_out),
   .scan_done_out (scan_done_out)
);

// >>> sim/loce_prog_model.sv
/*
 * Model of the stored sequence program: writes program words into the executor.
 * Assumes callers only write while the executor is stopped.
 */
module loce_prog_model
   import loce_pkg::*;
(
   input  wire logic              clock_in,
   output logic                   prog_we_out,
   output logic [7:0]             prog_addr_out,
   output loce_instr_t            prog_data_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      prog_we_out   = 1'b0;
      prog_addr_out = 8'h00;
      prog_data_out = '0;
   end

   // ****************************************
   // word write
   // ****************************************
   // callers keep one pulse per target per scan, shifts high to low,
   // levels opened rising and closed falling, end only as last word
   task put(input logic [7:0] a, input loce_instr_t d);
      @(posedge clock_in);
      #1;
      prog_we_out   = 1'b1;
      prog_addr_out = a;
      prog_data_out = d;
      @(posedge clock_in);
      #1;
      prog_we_out   = 1'b0;
      prog_addr_out = ~a; // released: no stale address left on the bus
   endtask : put
endmodule : loce_prog_model

// >>> sim/ladder_output_control_exec_bench.sv
/*
 * Self-checking bench of the ladder output control executor.
 * Assumes shortened time bases: 4 and 40 clocks.
 */
`include "loce_map.svh"

module ladder_output_control_exec_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import loce_pkg::*;

   logic              clock_in = 1'b0;
   logic              rst_in   = 1'b1;
   logic              run_in   = 1'b0;
   logic [63:0]       x_in     = 64'h0;
   logic [63:0]       y_out;
   logic [7:0]        step_out;
   logic              running_out, error_out, scan_done_out, prog_we;
   logic [7:0]        prog_addr;
   loce_instr_t       prog_data;
   int                failures = 0;
   int                tests_run = 0;
   int                n;

   always #10 clock_in = ~clock_in;

   loce_prog_model pm_u (.clock_in(clock_in), .prog_we_out(prog_we), .prog_addr_out(prog_addr),
                         .prog_data_out(prog_data));

   loce_exec #(.TICK10_CYC(4), .TICK100_CYC(40)) dut_u (
      .clock_in(clock_in), .rst_in(rst_in), .run_in(run_in), .prog_we_in(prog_we),
      .prog_addr_in(prog_addr), .prog_data_in(prog_data), .x_in(x_in), .y_out(y_out),
      .step_out(step_out), .running_out(running_out), .error_out(error_out),
      .scan_done_out(scan_done_out));

   // ****************************************
   // shared tasks
   // ****************************************
   task give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict

   task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      tests_run++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task cyc(input int k);
      repeat (k) @(posedge clock_in);
      #1;
   endtask : cyc

   task w(input logic [7:0] a, input logic [3:0] op, input logic [8:0] s, input logic [7:0] d, input logic [10:0] g);
      pm_u.put(a, {op, s, d, g});
   endtask : w

   task go;
      run_in = 1'b1;
      n = 0;
      do begin cyc(1); n++; end while (running_out !== 1'b1 && n < 300);
      if (n >= 300)
      begin
         failures++;
         give_verdict();
      end
   endtask : go

   task halt;
      run_in = 1'b0;
      cyc(2);
   endtask : halt

   // waits one whole scan; n holds its length in clocks
   task scan;
      n = 0;
      do begin cyc(1); n++; end while (scan_done_out !== 1'b1 && n < 100);
      if (n >= 100)
      begin
         failures++;
         give_verdict();
      end
   endtask : scan

   // ****************************************
   // scenarios
   // ****************************************
   task t_no_end;
      run_in = 1'b1;
      n = 0;
      do begin cyc(1); n++; end while (error_out !== 1'b1 && n < 300);
      chk("error_out", 64'h1, error_out);
      chk("running_out", 64'h0, running_out);
      halt();
   endtask : t_no_end

   task t_pulse;
      w(8'h00, `LOCE_OP_RISE, 9'h000, 8'h40, 11'h000);
      w(8'h01, `LOCE_OP_FALL, 9'h000, 8'h41, 11'h000);
      w(8'h02, `LOCE_OP_END, 9'h000, 8'h00, 11'h000);
      go();
      scan();
      x_in[0] = 1'b1;
      scan();
      chk("pulse rise", 64'h1, y_out[1:0]);
      scan();
      chk("pulse rise end", 64'h0, y_out[1:0]);
      chk("scan length", 64'd3, n);
      halt();
      go();
      scan();
      scan();
      chk("no refire", 64'h0, y_out[1:0]);
      x_in[0] = 1'b0;
      scan();
      chk("pulse fall", 64'h2, y_out[1:0]);
      scan();
      chk("pulse fall end", 64'h0, y_out[1:0]);
      halt();
   endtask : t_pulse

   task t_shift;
      w(8'h00, `LOCE_OP_SHIFT, 9'h000, 8'h48, 11'h000);
      w(8'h01, `LOCE_OP_SHIFT, 9'h000, 8'h47, 11'h000);
      w(8'h02, `LOCE_OP_SET, 9'h001, 8'h46, 11'h000);
      w(8'h03, `LOCE_OP_END, 9'h000, 8'h00, 11'h000);
      x_in[1] = 1'b1;
      go();
      scan();
      x_in[1:0] = 2'h1;
      scan();
      chk("shift one", 64'h2, y_out[8:6]);
      scan();
      chk("shift two", 64'h4, y_out[8:6]);
      scan();
      chk("shift out", 64'h0, y_out[8:6]);
      halt();
   endtask : t_shift

   task t_master;
      w(8'h00, `LOCE_OP_GATE_OPEN, 9'h001, 8'h60, 11'h000);
      w(8'h01, `LOCE_OP_GATE_OPEN, 9'h002, 8'h61, 11'h007);
      w(8'h02, `LOCE_OP_OUT, 9'h003, 8'h42, 11'h000);
      w(8'h03, `LOCE_OP_TMR10, 9'h003, 8'h00, 11'h002);
      w(8'h04, `LOCE_OP_SET, 9'h003, 8'h43, 11'h000);
      w(8'h05, `LOCE_OP_IDLE, 9'h000, 8'h00, 11'h000);
      w(8'h06, `LOCE_OP_GATE_CLOSE, 9'h000, 8'h00, 11'h000);
      w(8'h07, `LOCE_OP_OUT, 9'h100, 8'h44, 11'h000);
      w(8'h08, `LOCE_OP_GATE_OPEN, 9'h001, 8'h62, 11'h000);
      w(8'h09, `LOCE_OP_OUT, 9'h003, 8'h45, 11'h000);
      w(8'h0a, `LOCE_OP_GATE_CLOSE, 9'h000, 8'h00, 11'h000);
      w(8'h0b, `LOCE_OP_END, 9'h000, 8'h00, 11'h000);
      x_in[3:0] = 4'he;
      go();
      repeat (6) scan();
      chk("region on", 64'h3c, y_out[5:0] & 64'h3c);
      chk("control bits", 64'h7, y_out[34:32]);
      chk("scan on", 64'd12, n);
      x_in[2] = 1'b0;
      scan();
      scan();
      chk("region off", 64'h28, y_out[5:0] & 64'h3c);
      chk("scan off", 64'd12, n);
      x_in[1] = 1'b0;
      scan();
      scan();
      chk("reused level off", 64'h0, y_out[5]);
      halt();
   endtask : t_master

   // retentive timer and counter keep count and contact when the region closes
   task t_retain;
      w(8'h00, `LOCE_OP_GATE_OPEN, 9'h001, 8'h63, 11'h000);
      w(8'h01, `LOCE_OP_RTMR, 9'h003, 8'h01, 11'h001);
      w(8'h02, `LOCE_OP_CNT, 9'h003, 8'h02, 11'h001);
      w(8'h03, `LOCE_OP_GATE_CLOSE, 9'h000, 8'h00, 11'h000);
      w(8'h04, `LOCE_OP_OUT, 9'h101, 8'h46, 11'h000);
      w(8'h05, `LOCE_OP_OUT, 9'h102, 8'h47, 11'h000);
      w(8'h06, `LOCE_OP_END, 9'h000, 8'h00, 11'h000);
      x_in[3:0] = 4'ha;
      go();
      repeat (8) scan();
      chk("retain on", 64'h3, y_out[7:6]);
      x_in[1] = 1'b0;
      scan();
      scan();
      chk("retain off", 64'h3, y_out[7:6]);
      chk("control bit off", 64'h0, y_out[35]);
      halt();
   endtask : t_retain

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      cyc(10);
      rst_in = 1'b0;
      cyc(1);
      t_no_end();
      t_pulse();
      t_shift();
      t_master();
      t_retain();
      give_verdict();
   end
endmodule : ladder_output_control_exec_bench
